// >>> logic/srap_pkg.sv
/*
  srap_pkg: constants and types shared by the serial register access port.
  Assumes a single 40 MHz system clock; the cycle count SWITCH_WAIT_CYC below is derived from it.
*/
package srap_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned SCLK_MAX_HZ   = 26_000_000;
  localparam int unsigned I2C_MAX_BPS   = 3_400_000;
  localparam int unsigned SWITCH_WAIT_NS = 50;
  localparam int unsigned SWITCH_WAIT_CYC =
    (SWITCH_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned PAGE_W     = 2;
  localparam int unsigned REG_ADDR_W = PAGE_W + BYTE_W;
  localparam int unsigned WR_W       = REG_ADDR_W + BYTE_W;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned SYNC_W     = 6;

  // control byte fields
  localparam int unsigned CTRL_RW_BIT   = 7;
  localparam int unsigned CTRL_AI_BIT   = 6;
  localparam int unsigned CTRL_PAGE_MSB = 1;

  // synchroniser lane positions
  localparam int unsigned LN_SEL  = 0;
  localparam int unsigned LN_SCLK = 1;
  localparam int unsigned LN_MOSI = 2;
  localparam int unsigned LN_SCL  = 3;
  localparam int unsigned LN_SDA  = 4;
  localparam int unsigned LN_ISP  = 5;
  localparam logic [SYNC_W-1:0] SYNC_RST = 6'h19;

  // configuration values after reset
  localparam logic       RST_CPOL   = 1'h0;
  localparam logic       RST_CPHA   = 1'h0;
  localparam logic       RST_RWPOL  = 1'h0;
  localparam logic       RST_LFE    = 1'h1;
  localparam logic [1:0] RST_PINMODE = 2'h0;
  localparam logic [6:0] RST_I2C_ADDR = 7'h1F;

  typedef enum logic [2:0] {
    SRAP_IDLE,
    SRAP_CTRL,
    SRAP_ADDR,
    SRAP_LEN,
    SRAP_DATA,
    SRAP_WAIT
  } srap_state_t;

endpackage

// >>> logic/srap_stream_if.sv
/*
  srap_stream_if: valid/ready word carrier between the port and its write FIFO.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/10ps
interface srap_stream_if #(parameter int unsigned W = 18);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// >>> logic/srap_sync.sv
/*
  srap_sync: three-stage synchroniser for pin inputs with agreement filter.
  Assumes inputs are asynchronous to mclk_i; output follows once stages 2 and 3 agree.
*/
`timescale 1ns/10ps
module srap_sync #(
  parameter int unsigned       W   = 6,
  parameter logic [W-1:0]      RST = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic         clk_en_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s1_q    <= RST;
      s2_q    <= RST;
      s3_q    <= RST;
      level_o <= RST;
    end else if (clk_en_i) begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_o[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// >>> logic/srap_fifo.sv
/*
  srap_fifo: flip-flop FIFO with valid/ready on both sides.
  Assumes a single clock; ready on the fill side is low exactly when full.
*/
`timescale 1ns/10ps
module srap_fifo #(
  parameter int unsigned W     = 18,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  srap_stream_if.snk in_if,
  srap_stream_if.src out_if
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wptr_q;
  logic [AW:0]  rptr_q;
  wire          full  = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  wire          empty = (wptr_q == rptr_q);
  wire          push  = in_if.valid && !full;
  wire          pop   = out_if.ready && !empty;

  function automatic logic [AW:0] ptr_inc(input logic [AW:0] p);
    ptr_inc = p + 1'b1;
  endfunction

  assign in_if.ready  = !full;
  assign out_if.valid = !empty;
  assign out_if.data  = mem_q[rptr_q[AW-1:0]];

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else if (clk_en_i) begin
      if (push) begin
        wptr_q <= ptr_inc(wptr_q);
      end
      if (pop) begin
        rptr_q <= ptr_inc(rptr_q);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (clk_en_i && push) begin
      mem_q[wptr_q[AW-1:0]] <= in_if.data;
    end
  end

endmodule

// >>> logic/srap_top.sv
/*
  srap_top: byte-framed four-wire serial target for paged register access,
  interface selection, and two-wire target address recognition.
  Assumes pins are asynchronous and sampled by mclk_i; the serial clock must be
  slow enough (well under mclk/4) for edge recovery; registers answer reads in
  the same cycle as reg_rd_o.
*/
`timescale 1ns/10ps
module srap_top (
  input  wire logic                            mclk_i,
  input  wire logic                            reset_i,
  input  wire logic                            clk_en_i,
  input  wire logic                            sel_n_i,
  input  wire logic                            sclk_i,
  input  wire logic                            mosi_i,
  output logic                                 miso_o,
  input  wire logic                            scl_i,
  input  wire logic                            sda_i,
  output logic                                 sda_o,
  output logic                                 sda_oe_n_o,
  input  wire logic                            interface_select_pin_i,
  input  wire logic                            cfg_wr_i,
  input  wire logic                            clock_polarity_sel_i,
  input  wire logic                            clock_phase_sel_i,
  input  wire logic                            rw_flag_polarity_sel_i,
  input  wire logic                            length_field_enable_i,
  input  wire logic [1:0]                      pin_function_mode_i,
  input  wire logic                            otp_addr_load_i,
  input  wire logic [6:0]                      otp_addr_i,
  output logic                                 reg_wr_valid_o,
  output logic [srap_pkg::REG_ADDR_W-1:0]      reg_wr_addr_o,
  output logic [srap_pkg::BYTE_W-1:0]          reg_wr_data_o,
  input  wire logic                            reg_wr_ready_i,
  output logic                                 reg_rd_o,
  output logic [srap_pkg::REG_ADDR_W-1:0]      reg_rd_addr_o,
  input  wire logic [srap_pkg::BYTE_W-1:0]     reg_rd_data_i,
  output logic                                 spi_active_o,
  output logic                                 i2c_active_o,
  output logic                                 i2c_addr_hit_o,
  output logic                                 overrun_o,
  output logic                                 busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration and pin recovery

  logic                         cpol_q;
  logic                         cpha_q;
  logic                         rwpol_q;
  logic                         lfe_q;
  logic [1:0]                   pinmode_q;
  logic [6:0]                   i2c_addr_q;
  logic [srap_pkg::SYNC_W-1:0]  lvl;
  logic [srap_pkg::SYNC_W-1:0]  prev_q;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cpol_q    <= srap_pkg::RST_CPOL;
      cpha_q    <= srap_pkg::RST_CPHA;
      rwpol_q   <= srap_pkg::RST_RWPOL;
      lfe_q     <= srap_pkg::RST_LFE;
      pinmode_q <= srap_pkg::RST_PINMODE;
    end else if (clk_en_i && cfg_wr_i) begin
      cpol_q    <= clock_polarity_sel_i;
      cpha_q    <= clock_phase_sel_i;
      rwpol_q   <= rw_flag_polarity_sel_i;
      lfe_q     <= length_field_enable_i;
      pinmode_q <= pin_function_mode_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      i2c_addr_q <= srap_pkg::RST_I2C_ADDR;
    end else if (clk_en_i && otp_addr_load_i) begin
      i2c_addr_q <= otp_addr_i;
    end
  end

  srap_sync #(
    .W   (srap_pkg::SYNC_W),
    .RST (srap_pkg::SYNC_RST)
  ) u_sync (
    .mclk_i   (mclk_i),
    .reset_i  (reset_i),
    .clk_en_i (clk_en_i),
    .async_i  ({interface_select_pin_i, sda_i, scl_i, mosi_i, sclk_i, sel_n_i}),
    .level_o  (lvl)
  );

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      prev_q <= srap_pkg::SYNC_RST;
    end else if (clk_en_i) begin
      prev_q <= lvl;
    end
  end

  // other pin modes hand the pins elsewhere, so neither port listens
  wire mode0   = (pinmode_q == srap_pkg::RST_PINMODE);
  wire spi_en  = mode0 && !lvl[srap_pkg::LN_ISP];
  wire i2c_en  = mode0 && lvl[srap_pkg::LN_ISP];
  wire s_sel   = lvl[srap_pkg::LN_SEL];
  wire s_mosi  = lvl[srap_pkg::LN_MOSI];
  wire sc_rise = lvl[srap_pkg::LN_SCLK] && !prev_q[srap_pkg::LN_SCLK];
  wire sc_fall = !lvl[srap_pkg::LN_SCLK] && prev_q[srap_pkg::LN_SCLK];
  wire smp_on_fall = cpol_q ^ cpha_q;
  wire sample_e = smp_on_fall ? sc_fall : sc_rise;
  wire launch_e = smp_on_fall ? sc_rise : sc_fall;
  wire sel_act  = spi_en && !s_sel;
  wire sel_fall = sel_act && prev_q[srap_pkg::LN_SEL];

  ////////////////////////////////////////////////////////////////////////////
  // four-wire byte framing

  srap_pkg::srap_state_t            state_q;
  logic [2:0]                       bit_q;
  logic [srap_pkg::BYTE_W-2:0]      rx_q;
  logic                             is_read_q;
  logic                             ai_q;
  logic                             lfe_tr_q;
  logic [srap_pkg::PAGE_W-1:0]      page_q;
  logic [srap_pkg::REG_ADDR_W-1:0]  addr_q;
  logic [srap_pkg::BYTE_W-1:0]      cnt_q;
  logic [srap_pkg::BYTE_W-1:0]      tx_q;

  wire [srap_pkg::BYTE_W-1:0] rx_byte = {rx_q, s_mosi};
  wire byte_done = sel_act && !sel_fall && sample_e && (bit_q == 3'h7);
  wire in_data   = (state_q == srap_pkg::SRAP_DATA);
  wire last_byte = lfe_tr_q ? (cnt_q == 8'h01) : !ai_q;
  wire [srap_pkg::REG_ADDR_W-1:0] addr_first =
    {page_q, rx_byte};
  wire [srap_pkg::REG_ADDR_W-1:0] addr_next =
    addr_q + 10'h001;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bit_q <= 3'h0;
      rx_q  <= '0;
    end else if (clk_en_i) begin
      if (!sel_act || sel_fall) begin
        bit_q <= 3'h0;
      end else if (sample_e) begin
        bit_q <= bit_q + 3'h1;
        rx_q  <= rx_byte[srap_pkg::BYTE_W-2:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_q <= srap_pkg::SRAP_IDLE;
    end else if (clk_en_i) begin
      if (!sel_act) begin
        state_q <= srap_pkg::SRAP_IDLE;
      end else if (sel_fall) begin
        state_q <= srap_pkg::SRAP_CTRL;
      end else if (byte_done) begin
        case (state_q)
          srap_pkg::SRAP_CTRL: state_q <= srap_pkg::SRAP_ADDR;
          srap_pkg::SRAP_ADDR: state_q <= lfe_tr_q ? srap_pkg::SRAP_LEN : srap_pkg::SRAP_DATA;
          srap_pkg::SRAP_LEN:  state_q <= (rx_byte == 8'h00) ? srap_pkg::SRAP_WAIT : srap_pkg::SRAP_DATA;
          srap_pkg::SRAP_DATA: begin
            if (last_byte) begin
              state_q <= srap_pkg::SRAP_WAIT;
            end
          end
          srap_pkg::SRAP_WAIT: state_q <= srap_pkg::SRAP_WAIT;
          default:             state_q <= srap_pkg::SRAP_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      is_read_q <= 1'h0;
      ai_q      <= 1'h0;
      lfe_tr_q  <= srap_pkg::RST_LFE;
      page_q    <= '0;
    end else if (clk_en_i) begin
      if (sel_fall) begin
        lfe_tr_q <= lfe_q;
      end else if (byte_done && state_q == srap_pkg::SRAP_CTRL) begin
        is_read_q <= rx_byte[srap_pkg::CTRL_RW_BIT] ^ rwpol_q;
        ai_q      <= rx_byte[srap_pkg::CTRL_AI_BIT];
        page_q    <= rx_byte[srap_pkg::CTRL_PAGE_MSB:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      addr_q <= '0;
      cnt_q  <= '0;
    end else if (clk_en_i && byte_done) begin
      if (state_q == srap_pkg::SRAP_ADDR) begin
        addr_q <= addr_first;
      end else if (state_q == srap_pkg::SRAP_LEN) begin
        cnt_q <= rx_byte;
      end else if (in_data) begin
        addr_q <= addr_next;
        cnt_q  <= cnt_q - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read fetch and serial output

  wire fetch_go = byte_done && is_read_q && (
                    (state_q == srap_pkg::SRAP_ADDR && !lfe_tr_q) ||
                    (state_q == srap_pkg::SRAP_LEN && rx_byte != 8'h00) ||
                    (in_data && !last_byte));
  wire [srap_pkg::REG_ADDR_W-1:0] fetch_addr =
    (state_q == srap_pkg::SRAP_ADDR) ? addr_first :
    (state_q == srap_pkg::SRAP_LEN)  ? addr_q : addr_next;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      reg_rd_o      <= 1'h0;
      reg_rd_addr_o <= '0;
    end else if (clk_en_i) begin
      reg_rd_o <= fetch_go;
      if (fetch_go) begin
        reg_rd_addr_o <= fetch_addr;
      end
    end
  end

  // data is fetched half a serial clock ahead, which bounds the serial rate
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tx_q   <= '0;
      miso_o <= 1'h0;
    end else if (clk_en_i) begin
      if (!sel_act || sel_fall) begin
        tx_q   <= '0;
        miso_o <= 1'h0;
      end else if (reg_rd_o) begin
        tx_q <= reg_rd_data_i;
      end else if (launch_e) begin
        miso_o <= tx_q[srap_pkg::BYTE_W-1];
        tx_q   <= {tx_q[srap_pkg::BYTE_W-2:0], 1'h0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write path through the FIFO

  srap_stream_if #(.W(srap_pkg::WR_W)) wr_in ();
  srap_stream_if #(.W(srap_pkg::WR_W)) wr_out ();

  wire push_go = byte_done && in_data && !is_read_q;
  assign wr_in.valid  = push_go;
  assign wr_in.data   = {addr_q, rx_byte};
  assign wr_out.ready = !reg_wr_valid_o || reg_wr_ready_i;

  srap_fifo #(
    .W     (srap_pkg::WR_W),
    .DEPTH (srap_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_i   (mclk_i),
    .reset_i  (reset_i),
    .clk_en_i (clk_en_i),
    .in_if    (wr_in),
    .out_if   (wr_out)
  );

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      reg_wr_valid_o <= 1'h0;
      reg_wr_addr_o  <= '0;
      reg_wr_data_o  <= '0;
    end else if (clk_en_i) begin
      if (wr_out.valid && wr_out.ready) begin
        reg_wr_valid_o <= 1'h1;
        {reg_wr_addr_o, reg_wr_data_o} <= wr_out.data;
      end else if (reg_wr_ready_i) begin
        reg_wr_valid_o <= 1'h0;
      end
    end
  end

  // host cannot be stalled mid-byte, so a full FIFO drops and flags the byte
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      overrun_o <= 1'h0;
    end else if (clk_en_i) begin
      if (push_go && !wr_in.ready) begin
        overrun_o <= 1'h1;
      end else if (sel_fall) begin
        overrun_o <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-wire address recognition and status

  logic       i2c_listen_q;
  logic       ack_pend_q;
  logic [3:0] i2c_bit_q;
  logic [6:0] i2c_sr_q;

  wire scl_hi  = lvl[srap_pkg::LN_SCL] && prev_q[srap_pkg::LN_SCL];
  wire scl_r   = lvl[srap_pkg::LN_SCL] && !prev_q[srap_pkg::LN_SCL];
  wire scl_f   = !lvl[srap_pkg::LN_SCL] && prev_q[srap_pkg::LN_SCL];
  wire i2c_st  = i2c_en && scl_hi && prev_q[srap_pkg::LN_SDA] && !lvl[srap_pkg::LN_SDA];
  wire i2c_sp  = i2c_en && scl_hi && !prev_q[srap_pkg::LN_SDA] && lvl[srap_pkg::LN_SDA];
  wire i2c_end = i2c_listen_q && scl_r && (i2c_bit_q == 4'h7);
  // first seven bits are the address, the eighth (read/write) is not compared
  wire i2c_hit = i2c_end && (i2c_sr_q == i2c_addr_q);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      i2c_listen_q <= 1'h0;
      i2c_bit_q    <= 4'h0;
      i2c_sr_q     <= '0;
    end else if (clk_en_i) begin
      if (i2c_st) begin
        i2c_listen_q <= 1'h1;
        i2c_bit_q    <= 4'h0;
      end else if (i2c_sp || !i2c_en || i2c_end) begin
        i2c_listen_q <= 1'h0;
      end else if (i2c_listen_q && scl_r) begin
        i2c_sr_q  <= {i2c_sr_q[5:0], lvl[srap_pkg::LN_SDA]};
        i2c_bit_q <= i2c_bit_q + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ack_pend_q     <= 1'h0;
      sda_oe_n_o     <= 1'h1;
      sda_o          <= 1'h0;
      i2c_addr_hit_o <= 1'h0;
    end else if (clk_en_i) begin
      i2c_addr_hit_o <= i2c_hit;
      if (i2c_sp || !i2c_en) begin
        ack_pend_q <= 1'h0;
        sda_oe_n_o <= 1'h1;
      end else if (i2c_hit) begin
        ack_pend_q <= 1'h1;
      end else if (scl_f && ack_pend_q) begin
        ack_pend_q <= 1'h0;
        sda_oe_n_o <= 1'h0;
      end else if (scl_f) begin
        sda_oe_n_o <= 1'h1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      spi_active_o <= 1'h0;
      i2c_active_o <= 1'h0;
      busy_o       <= 1'h0;
    end else if (clk_en_i) begin
      spi_active_o <= spi_en;
      i2c_active_o <= i2c_en;
      busy_o       <= sel_act || reg_wr_valid_o || wr_out.valid;
    end
  end

endmodule

// >>> verification/srap_host_model.sv
/* srap_host_model: four-wire host; assumes mclk_i for pacing its edges. */
`timescale 1ns/10ps
module srap_host_model (
  input  wire logic mclk_i,
  input  wire logic miso_i,
  output logic      sel_n_o,
  output logic      sclk_o,
  output logic      mosi_o
);
  int half = 4;
  initial begin
    sel_n_o = 1'h1;
    sclk_o  = 1'h0;
    mosi_o  = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // released data line shows junk, not the last bit
  task automatic sel(input logic v);
    tick(half);
    sel_n_o = v;
    mosi_o  = ~mosi_o;
    tick(half);
  endtask
  // launch on fall, sample on rise
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nb; i--) begin
      mosi_o = tx[i];
      tick(half);
      sclk_o = 1'h1;
      rx[i]  = miso_i;
      tick(half);
      sclk_o = 1'h0;
    end
  endtask
endmodule

// >>> verification/srap_chk.sv
/* srap_chk: port assertions; bound into every srap_top below. */
`timescale 1ns/10ps
module srap_chk (
  input wire logic       mclk_i,
  input wire logic       reset_i,
  input wire logic       sel_n_i,
  input wire logic       miso_o,
  input wire logic       sda_o,
  input wire logic       sda_oe_n_o,
  input wire logic       overrun_o,
  input wire logic       interface_select_pin_i,
  input wire logic [1:0] pin_function_mode_i,
  input wire logic       reg_wr_valid_o,
  input wire logic [9:0] reg_wr_addr_o,
  input wire logic [7:0] reg_wr_data_o,
  input wire logic       reg_wr_ready_i,
  input wire logic       reg_rd_o,
  input wire logic [9:0] reg_rd_addr_o,
  input wire logic       spi_active_o,
  input wire logic       i2c_active_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic [9:0] last_q;
  logic       seen_q;
  // raw select clears early, safe since no read ends then
  always_ff @(posedge mclk_i) begin
    if (reset_i || sel_n_i) seen_q <= 1'h0;
    else if (reg_rd_o) seen_q <= 1'h1;
  end
  always_ff @(posedge mclk_i) begin
    if (reg_rd_o) last_q <= reg_rd_addr_o;
  end
  a_miso_idle: assert property (sel_n_i [*8] |-> !miso_o)
    else $error("miso high while deselected");
  a_reset_values: assert property ($fell(reset_i) |-> !miso_o && !reg_rd_o && !reg_wr_valid_o && sda_oe_n_o)
    else $error("outputs not at reset values");
  a_write_hold: assert property (reg_wr_valid_o && !reg_wr_ready_i |=>
    reg_wr_valid_o && $stable(reg_wr_addr_o) && $stable(reg_wr_data_o))
    else $error("write word dropped or changed");
  a_read_addr_inc: assert property (reg_rd_o && seen_q |-> reg_rd_addr_o == last_q + 10'h1)
    else $error("read address not incremented");
  a_read_in_spi: assert property (reg_rd_o |-> spi_active_o)
    else $error("read while four-wire port off");
  a_port_excl: assert property (!(spi_active_o && i2c_active_o))
    else $error("both ports active");
  a_spi_chosen: assert property ((pin_function_mode_i == 2'h0 && !interface_select_pin_i) [*8] |-> spi_active_o)
    else $error("four-wire port not selected");
  a_sda_open: assert property (!sda_o)
    else $error("sda driven high");
  a_ack_in_i2c: assert property (!sda_oe_n_o |-> i2c_active_o)
    else $error("sda pulled outside two-wire mode");
  cover property (!sda_oe_n_o);
  cover property (reg_wr_valid_o && reg_wr_ready_i);
  cover property (reg_rd_o && seen_q);
  cover property ($rose(overrun_o));
endmodule
bind srap_top srap_chk u_chk (.*);

// >>> verification/srap_top_test.sv
/* srap_top_test: host model drives srap_top; bench models the register file. */
`timescale 1ns/10ps
`define CHK(n,e,g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module srap_top_test;
  logic        mclk_i = 0, reset_i = 1, cfg_wr_i = 0, lfe = 1, rdy = 1, isp = 0;
  logic        sel_n, sclk, mosi, miso, wv, rd, ovr, busy, spi_on, i2c_on;
  logic [9:0]  wa, ra;
  logic [7:0]  wd;
  logic        en = 1'h1, scl = 1'h1, sda = 1'h1, rwp = 1'h0, ol = 1'h0, hit, sda_out, oe_n;
  logic [1:0]  pm = 2'h0;
  logic [6:0]  oa = 7'h00;
  int          hits = 0;
  // open drain: line low when either side pulls
  wire         sda_pin = sda & oe_n;
  logic [7:0]  rx[$];
  logic [17:0] q[$];
  int          n_errors = 0, tests_run = 0;
  initial forever #12.5 mclk_i = ~mclk_i;
  srap_host_model h (.mclk_i(mclk_i), .miso_i(miso), .sel_n_o(sel_n), .sclk_o(sclk), .mosi_o(mosi));
  srap_top DUT (.mclk_i(mclk_i), .reset_i(reset_i), .clk_en_i(en), .sel_n_i(sel_n), .sclk_i(sclk),
    .mosi_i(mosi), .miso_o(miso), .scl_i(scl), .sda_i(sda_pin), .sda_o(sda_out), .sda_oe_n_o(oe_n),
    .interface_select_pin_i(isp), .cfg_wr_i(cfg_wr_i), .clock_polarity_sel_i(1'h0), .clock_phase_sel_i(1'h0),
    .rw_flag_polarity_sel_i(rwp), .length_field_enable_i(lfe), .pin_function_mode_i(pm),
    .otp_addr_load_i(ol), .otp_addr_i(oa), .reg_wr_valid_o(wv), .reg_wr_addr_o(wa), .reg_wr_data_o(wd),
    .reg_wr_ready_i(rdy), .reg_rd_o(rd), .reg_rd_addr_o(ra), .reg_rd_data_i(ra[7:0] ^ 8'hA5),
    .spi_active_o(spi_on), .i2c_active_o(i2c_on), .i2c_addr_hit_o(hit), .overrun_o(ovr), .busy_o(busy));
  always @(posedge mclk_i) if (wv && rdy) q.push_back({wa, wd});
  always @(posedge mclk_i) if (hit === 1'h1) hits++;
  ////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cfg(input logic l, input logic r, input logic [1:0] m);
    lfe = l;
    rwp = r;
    pm  = m;
    cfg_wr_i = 1;
    h.tick(1);
    cfg_wr_i = 0;
  endtask
  // frame, then let pending writes drain
  task automatic send(input logic [7:0] b[$], input int last_nb = 8);
    logic [7:0] r;
    int i;
    q = {};
    rx = {};
    h.sel(0);
    foreach (b[k]) begin
      h.xfer(b[k], (k == b.size() - 1) ? last_nb : 8, r);
      rx.push_back(r);
    end
    h.sel(1);
    rdy = 1;
    for (i = 0; i < 500 && busy !== 1'h0; i++) h.tick(1);
    if (busy !== 1'h0) begin n_errors++; end_of_test; end
    h.tick(4);
  endtask
  task automatic t_len_write;
    send('{8'h02, 8'hFE, 8'h03, 8'h11, 8'h22, 8'h33, 8'h44});
    `CHK("wr count", 3, q.size())
    for (int i = 0; i < 3; i++) `CHK("wr word", {10'h2FE + 10'(i), 8'(8'h11 * (i + 1))}, q[i])
  endtask
  task automatic t_partial;
    send('{8'h00, 8'h10, 8'h02, 8'h55, 8'h66}, 4);
    `CHK("wr count", 1, q.size())
    `CHK("wr word", {10'h010, 8'h55}, q[0])
  endtask
  task automatic t_len_read;
    h.half = 8;
    send('{8'h81, 8'h40, 8'h02, 8'h00, 8'h00, 8'h00});
    `CHK("rd 0", 8'hE5, rx[3])
    `CHK("rd 1", 8'hE4, rx[4])
    `CHK("rd stop", 8'h00, rx[5])
    cfg(1'h1, 1'h1, 2'h0);
    send('{8'h01, 8'h10, 8'h01, 8'h00});
    `CHK("rd pol", 8'hB5, rx[3])
    `CHK("rd pol wr", 0, q.size())
    cfg(1'h1, 1'h0, 2'h0);
    h.half = 4;
  endtask
  // stalled register file fills the write buffer
  task automatic t_stream;
    cfg(1'h0, 1'h0, 2'h0);
    rdy = 0;
    send('{8'h40, 8'h20, 1, 2, 3, 4, 5, 6, 7, 8, 9});
    `CHK("overrun", 1'h1, ovr)
    `CHK("wr a", {10'h020, 8'h01}, q[0])
    `CHK("wr b", {10'h021, 8'h02}, q[1])
    send('{8'h00, 8'h30, 8'h77, 8'h88});
    `CHK("wr count", 1, q.size())
    h.half = 8;
    send('{8'hC0, 8'h05, 8'h00, 8'h00, 8'h00});
    for (int i = 0; i < 3; i++) `CHK("rd ai", (8'h05 + 8'(i)) ^ 8'hA5, rx[2 + i])
    h.half = 4;
    cfg(1'h1, 1'h0, 2'h0);
  endtask
  // start, address byte with write flag, ack clock, stop
  task automatic i2c_addr(input logic [6:0] a, input logic exp);
    logic [7:0] b;
    int         h0;
    b = {a, 1'h0};
    h0 = hits;
    sda = 1'h0;
    h.tick(6);
    scl = 1'h0;
    for (int i = 7; i >= 0; i--) begin
      h.tick(2);
      sda = b[i];
      h.tick(6);
      scl = 1'h1;
      h.tick(6);
      scl = 1'h0;
    end
    h.tick(2);
    sda = 1'h1;
    h.tick(6);
    `CHK("ack", !exp, oe_n)
    scl = 1'h1;
    h.tick(6);
    scl = 1'h0;
    h.tick(8);
    `CHK("ack release", 1'h1, oe_n)
    `CHK("addr hit", exp, hits - h0)
    sda = 1'h0;
    h.tick(6);
    scl = 1'h1;
    h.tick(6);
    sda = 1'h1;
    h.tick(6);
  endtask
  task automatic t_i2c;
    i2c_addr(7'h1F, 1'h1);
    oa = 7'h2A;
    ol = 1'h1;
    h.tick(1);
    ol = 1'h0;
    i2c_addr(7'h1F, 1'h0);
    i2c_addr(7'h2A, 1'h1);
    `CHK("sda out", 1'h0, sda_out)
  endtask
  task automatic t_switch;
    cfg(1'h1, 1'h0, 2'h1);
    h.tick(8);
    `CHK("mode off", 2'h0, {spi_on, i2c_on})
    cfg(1'h1, 1'h0, 2'h0);
    h.tick(2);
    en = 1'h0;
    isp = 1;
    h.tick(8);
    `CHK("frozen", 1'h1, spi_on)
    en = 1'h1;
    h.tick(8);
    `CHK("spi off", 1'h0, spi_on)
    `CHK("i2c on", 1'h1, i2c_on)
    t_i2c;
    isp = 0;
    h.tick(8);
    `CHK("spi on", 1'h1, spi_on)
  endtask
  initial begin
    repeat (16) @(posedge mclk_i);
    #1 reset_i = 0;
    t_len_write;
    t_partial;
    t_len_read;
    t_stream;
    t_switch;
    end_of_test;
  end
endmodule
